//--- verilog/ihb_pkg.sv
// Package: constants, states and carriers of the halt/branch/input block
package ihb_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_CTRL = 8'h08;
	localparam logic [7:0] OFS_OPA = 8'h0c;
	localparam logic [7:0] OFS_OPB = 8'h10;
	localparam logic [7:0] OFS_CMP = 8'h14;
	localparam logic [7:0] OFS_INP = 8'h18;
	localparam logic [7:0] OFS_RES = 8'h1c;
	localparam logic [7:0] OFS_ERR = 8'h20;
	localparam logic [7:0] OFS_LREG = 8'h40;
	// Command codes in command register bits 3:0
	localparam logic [3:0] CMD_HALT = 4'h1;
	localparam logic [3:0] CMD_MSTOP = 4'h2;
	localparam logic [3:0] CMD_EXEC = 4'h3;
	localparam logic [3:0] CMD_PROG = 4'h4;
	localparam logic [3:0] CMD_EXIT = 4'h5;
	localparam logic [3:0] CMD_IF = 4'h6;
	localparam logic [3:0] CMD_RDIN = 4'h7;
	localparam logic [3:0] CMD_RREG = 4'h8;
	localparam logic [3:0] CMD_RFLAG = 4'h9;
	localparam logic [3:0] CMD_HOME = 4'ha;
	// Command field positions
	localparam int CF_DST = 8;
	localparam int CF_ADR = 16;
	localparam int CF_ITEM = 24;
	// Compare operators
	localparam logic [1:0] OP_GT = 2'h0;
	localparam logic [1:0] OP_LT = 2'h1;
	localparam logic [1:0] OP_NE = 2'h2;
	localparam logic [1:0] OP_EQ = 2'h3;
	// Operand sources
	localparam logic [1:0] SRC_CONST = 2'h0;
	localparam logic [1:0] SRC_LREG = 2'h1;
	localparam logic [1:0] SRC_BIT = 2'h2;
	localparam logic [1:0] SRC_BYTE = 2'h3;
	// Error flag bit positions
	localparam int EB_COMM = 0;
	localparam int EB_TOUT = 1;
	localparam int EB_UNKN = 2;
	localparam int EB_WIRE = 3;
	localparam int EB_RANGE = 4;
	// Remote answer error codes
	localparam logic [1:0] RE_OK = 2'h0;
	localparam logic [1:0] RE_COMM = 2'h1;
	localparam logic [1:0] RE_UNKN = 2'h2;
	localparam logic [1:0] RE_WIRE = 2'h3;
	// Limits, reset values, timing
	localparam logic [7:0] MAX_MOD_ADDR = 8'h1f;
	localparam logic [31:0] RST_CMP = 32'h0000_0000;
	localparam logic RST_HSSE = 1'b0;
	localparam int CLK_MHZ = 10;
	localparam int BUS_TIMEOUT_US = 2000;
	// Operating modes
	typedef enum logic [1:0] {M_STANDBY, M_PROGRAM, M_RUNNING} ihb_mode_t;
	// Remote read sequencer states
	typedef enum logic {R_IDLE, R_WAIT} ihb_rstate_t;
	// Expansion bus request and answer
	typedef struct packed {
		logic valid;
		logic flag;
		logic [4:0] addr;
		logic [7:0] item;
	} ihb_rreq_t;
	typedef struct packed {
		logic done;
		logic [1:0] err;
		logic [31:0] data;
	} ihb_rrsp_t;
endpackage

//--- verilog/ihb_core.sv
// Halt, conditional skip, input read and remote read command logic
//
// Function
// RQ1 - Halt stops motor instantly, no ramp
// RQ2 - Halt overrides all activity, ends program
// RQ3 - Halt enters standby at once
// RQ4 - Execute after halt restarts at line zero
// RQ5 - Halt accepted in every mode
// RQ6 - Halt clears high-speed start enable
// RQ7 - Motor stop keeps program running
// RQ8 - Host homes before rerun after halt
// RQ9 - Compare two operands with four operators
// RQ10 - True runs next line, false skips it
// RQ11 - Inputs usable directly as operands
// RQ12 - Read one input bit or byte
// RQ13 - Input eight is byte MSB
// RQ14 - Byte patterns allow don't-care bits
// RQ15 - Extended inputs nine to sixteen mapping
// RQ16 - Analogue input read as digital bit
// RQ17 - Remote register read into local register
// RQ18 - Module address limited to 0..31
// RQ19 - Register selector within 0..255
// RQ20 - Remote flag read into local register
// RQ21 - Modules have unique address, one register
// RQ22 - Failed remote read ignored, flag set
// RQ23 - Failed read leaves destination unchanged
`timescale 1ns/1ps
module ihb_core import ihb_pkg::*; #(
	parameter int NLREG = 16,
	parameter int TIMEOUT_CYC = BUS_TIMEOUT_US * CLK_MHZ
) (
	// Clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Local and extended inputs
	input wire logic [7:0] in_pins,
	input wire logic negative_limit_input,
	input wire logic positive_limit_input,
	input wire logic home_input,
	input wire logic analogue_input_one,
	input wire logic analogue_input_two,
	input wire logic output_fault,
	// Motion unit link
	output logic motor_halt_now,
	output logic motor_stop_req,
	output logic home_search_command,
	output logic high_speed_start_enable,
	output logic [15:0] line_ptr,
	// Expansion bus
	output ihb_rreq_t rbus_req,
	input wire ihb_rrsp_t rbus_rsp
);
	// Write channel capture
	logic aw_full;
	logic w_full;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_go;
	// Mode and working registers
	ihb_mode_t mode_reg;
	ihb_rstate_t rst_reg;
	logic [31:0] opa_reg;
	logic [31:0] opb_reg;
	logic [31:0] cmp_reg;
	logic [31:0] res_reg;
	logic [4:0] err_reg;
	logic [4:0] err_set;
	logic [31:0] lreg [NLREG];
	logic [3:0] rdst_reg;
	logic [31:0] tcnt_reg;
	logic last_cmp_reg;
	// Decoded command strobes
	logic [3:0] code;
	logic cmd_go;
	logic is_halt;
	logic cmp_now;
	logic [15:0] all_in;
	logic [7:0] mod_adr;
	logic rd_ok;
	logic rsp_take;

	// IN16..IN9: reserved, fault, reserved, ai2, ai1, home, +lim, -lim
	// RQ15 extended map
	assign all_in = {1'b0, output_fault, 1'b0, analogue_input_two,
		analogue_input_one, home_input, positive_limit_input,
		negative_limit_input, in_pins};

	// Selects input n (1..16); zero yields zero
	function automatic logic in_sel(input logic [4:0] n);
		in_sel = 1'b0;
		if (n != 5'h00 && n <= 5'h10) begin
			in_sel = all_in[4'(n - 5'h01)];
		end
	endfunction

	// Resolves an operand from its source and raw field
	function automatic logic [31:0] opnd(input logic [1:0] src,
		input logic [31:0] raw);
		case (src)
			SRC_LREG: opnd = lreg[raw[3:0]];
			// RQ11 input as operand
			SRC_BIT: opnd = {31'h0, in_sel(raw[4:0])};
			// RQ14 care mask blanks x digits
			SRC_BYTE: opnd = {24'h0, in_pins & cmp_reg[15:8]};
			default: opnd = raw;
		endcase
	endfunction

	// Signed comparison of two operands
	function automatic logic cmp_fn(input logic [1:0] op,
		input logic [31:0] a, input logic [31:0] b);
		case (op)
			OP_GT: cmp_fn = $signed(a) > $signed(b);
			OP_LT: cmp_fn = $signed(a) < $signed(b);
			OP_NE: cmp_fn = a != b;
			default: cmp_fn = a == b;
		endcase
	endfunction

	// Write strobe and command decode
	assign wr_go = ce & aw_full & w_full & ~s_axi_bvalid;
	assign cmd_go = wr_go & (aw_addr == OFS_CMD) & w_strb[0];
	assign code = w_data[3:0];
	assign is_halt = cmd_go & (code == CMD_HALT);
	assign mod_adr = w_data[CF_ADR +: 8];
	// RQ9 operand compare
	assign cmp_now = cmp_fn(cmp_reg[1:0], opnd(cmp_reg[3:2], opa_reg),
		opnd(cmp_reg[5:4], opb_reg));
	// RQ18 address range gate
	assign rd_ok = mod_adr <= MAX_MOD_ADDR;
	assign rsp_take = ce & (rst_reg == R_WAIT) & rbus_rsp.done;

	// Address and data are taken independently, held until written
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else if (ce) begin
			s_axi_awready <= ~aw_full & ~s_axi_awready;
			s_axi_wready <= ~w_full & ~s_axi_wready;
			if (s_axi_awvalid & s_axi_awready) begin
				aw_full <= 1'b1;
				aw_addr <= {s_axi_awaddr[7:2], 2'b00};
			end else if (wr_go) begin
				aw_full <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_full <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_go) begin
				w_full <= 1'b0;
			end
		end
	end

	// Write response one cycle after both halves are present
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else if (ce) begin
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				// Unmapped addresses answer SLVERR
				s_axi_bresp <= (aw_addr > OFS_ERR && aw_addr < OFS_LREG)
					? 2'b10 : 2'b00;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel: data one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'b00;
		end else if (ce) begin
			s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'b00;
				if (s_axi_araddr >= OFS_LREG) begin
					s_axi_rdata <= lreg[s_axi_araddr[5:2]];
				end else begin
					case ({s_axi_araddr[7:2], 2'b00})
						OFS_STAT: s_axi_rdata <= {line_ptr, 11'h0,
							last_cmp_reg, rst_reg == R_WAIT,
							high_speed_start_enable, mode_reg};
						OFS_CTRL: s_axi_rdata <= {31'h0,
							high_speed_start_enable};
						OFS_OPA: s_axi_rdata <= opa_reg;
						OFS_OPB: s_axi_rdata <= opb_reg;
						OFS_CMP: s_axi_rdata <= cmp_reg;
						// RQ13 IN8 is bit 7
						OFS_INP: s_axi_rdata <= {16'h0, all_in};
						OFS_RES: s_axi_rdata <= res_reg;
						OFS_ERR: s_axi_rdata <= {27'h0, err_reg};
						OFS_CMD: s_axi_rdata <= 32'h0;
						default: begin
							s_axi_rdata <= 32'h0;
							s_axi_rresp <= 2'b10;
						end
					endcase
				end
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Operand and compare configuration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			opa_reg <= 32'h0;
			opb_reg <= 32'h0;
			cmp_reg <= RST_CMP;
		end else if (wr_go) begin
			if (aw_addr == OFS_OPA) opa_reg <= w_data;
			if (aw_addr == OFS_OPB) opb_reg <= w_data;
			if (aw_addr == OFS_CMP) cmp_reg <= w_data;
		end
	end

	// Operating mode; halt wins over everything in any mode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_reg <= M_STANDBY;
		end else if (is_halt) begin
			// RQ2 RQ3 RQ5 halt to standby
			mode_reg <= M_STANDBY;
		end else if (cmd_go) begin
			case (mode_reg)
				M_STANDBY: begin
					if (code == CMD_EXEC) mode_reg <= M_RUNNING;
					if (code == CMD_PROG) mode_reg <= M_PROGRAM;
				end
				M_PROGRAM: begin
					if (code == CMD_EXIT) mode_reg <= M_STANDBY;
				end
				M_RUNNING: mode_reg <= M_RUNNING;
				default: mode_reg <= M_STANDBY;
			endcase
		end
	end

	// Program line pointer: restart and conditional skip
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			line_ptr <= 16'h0;
			last_cmp_reg <= 1'b0;
		end else if (cmd_go) begin
			if (code == CMD_EXEC && mode_reg == M_STANDBY) begin
				// RQ4 restart at first line
				line_ptr <= 16'h0;
			end else if (code == CMD_IF && mode_reg != M_STANDBY) begin
				last_cmp_reg <= cmp_now;
				// RQ10 skip one line on false
				line_ptr <= line_ptr + (cmp_now ? 16'h1 : 16'h2);
			end
		end
	end

	// Motion unit requests are one-cycle pulses
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			motor_halt_now <= 1'b0;
			motor_stop_req <= 1'b0;
			home_search_command <= 1'b0;
		end else if (ce) begin
			// RQ1 instant halt, no ramp
			motor_halt_now <= is_halt;
			// RQ7 stop without leaving run
			motor_stop_req <= cmd_go & (code == CMD_MSTOP);
			// RQ8 host-issued home search
			home_search_command <= cmd_go & (code == CMD_HOME);
		end
	end

	// High-speed start enable; halt clears it until software sets it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			high_speed_start_enable <= RST_HSSE;
		end else if (is_halt) begin
			// RQ6 halt clears enable
			high_speed_start_enable <= 1'b0;
		end else if (wr_go && aw_addr == OFS_CTRL && w_strb[0]) begin
			high_speed_start_enable <= w_data[0];
		end
	end

	// Input read result
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			res_reg <= 32'h0;
		end else if (cmd_go && code == CMD_RDIN) begin
			// RQ12 RQ16 bit or byte read
			res_reg <= (w_data[CF_ADR +: 5] == 5'h00)
				? {24'h0, in_pins}
				: {31'h0, in_sel(w_data[CF_ADR +: 5])};
		end
	end

	// Remote read sequencer; halt abandons an outstanding read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rst_reg <= R_IDLE;
			rbus_req <= '0;
			rdst_reg <= 4'h0;
			tcnt_reg <= 32'h0;
		end else if (is_halt) begin
			rst_reg <= R_IDLE;
			rbus_req <= '0;
		end else if (ce) begin
			case (rst_reg)
				R_IDLE: begin
					tcnt_reg <= 32'h0;
					// RQ17 RQ19 RQ20 start read
					if (cmd_go && rd_ok &&
						(code == CMD_RREG || code == CMD_RFLAG)) begin
						rst_reg <= R_WAIT;
						rbus_req.valid <= 1'b1;
						rbus_req.flag <= code == CMD_RFLAG;
						rbus_req.addr <= mod_adr[4:0];
						rbus_req.item <= w_data[CF_ITEM +: 8];
						rdst_reg <= w_data[CF_DST +: 4];
					end
				end
				R_WAIT: begin
					tcnt_reg <= tcnt_reg + 32'h1;
					if (rbus_rsp.done ||
						tcnt_reg == 32'(TIMEOUT_CYC - 1)) begin
						rst_reg <= R_IDLE;
						rbus_req.valid <= 1'b0;
					end
				end
				default: rst_reg <= R_IDLE;
			endcase
		end
	end

	// Local registers: software window and remote results
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < NLREG; i++) lreg[i] <= 32'h0;
		end else begin
			if (wr_go && aw_addr >= OFS_LREG) begin
				lreg[aw_addr[5:2]] <= w_data;
			end
			// RQ23 only a clean answer writes
			if (rsp_take && rbus_rsp.err == RE_OK) begin
				lreg[rdst_reg] <= rbus_req.flag
					? {31'h0, rbus_rsp.data[0]} : rbus_rsp.data;
			end
		end
	end

	// Error events of this cycle
	always_comb begin
		err_set = 5'h0;
		// RQ22 failed read sets flag
		if (rsp_take) begin
			err_set[EB_COMM] = rbus_rsp.err == RE_COMM;
			err_set[EB_UNKN] = rbus_rsp.err == RE_UNKN;
			err_set[EB_WIRE] = rbus_rsp.err == RE_WIRE;
		end
		err_set[EB_TOUT] = ce & (rst_reg == R_WAIT) & ~rbus_rsp.done &
			(tcnt_reg == 32'(TIMEOUT_CYC - 1));
		// RQ18 out-of-range address refused
		err_set[EB_RANGE] = cmd_go & ~rd_ok &
			(code == CMD_RREG || code == CMD_RFLAG);
	end

	// Sticky flags, write one to clear; a new event beats the clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			err_reg <= 5'h0;
		end else if (ce) begin
			if (wr_go && aw_addr == OFS_ERR) begin
				err_reg <= (err_reg & ~w_data[4:0]) | err_set;
			end else begin
				err_reg <= err_reg | err_set;
			end
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_halt_cmd;
		is_halt;
	endsequence
	sequence s_halted;
		mode_reg == M_STANDBY && motor_halt_now && rst_reg == R_IDLE;
	endsequence

	AST_HALT_STANDBY: assert property (s_halt_cmd |=> s_halted) // RQ3
		else $error("halt did not reach standby");
	AST_HALT_HSSE: assert property (s_halt_cmd |=> // RQ6
		!high_speed_start_enable)
		else $error("halt left high-speed start enabled");
	AST_EXEC_LINE0: assert property (cmd_go && code == CMD_EXEC && // RQ4
		mode_reg == M_STANDBY |=> mode_reg == M_RUNNING && line_ptr == 0)
		else $error("execute did not restart at line zero");
	AST_MSTOP_RUN: assert property (cmd_go && code == CMD_MSTOP && // RQ7
		mode_reg == M_RUNNING |=> motor_stop_req && mode_reg == M_RUNNING)
		else $error("motor stop ended program");
	AST_IF_SKIP: assert property (cmd_go && code == CMD_IF && // RQ10
		mode_reg == M_RUNNING |=> line_ptr ==
		$past(line_ptr) + ($past(cmp_now) ? 16'h1 : 16'h2))
		else $error("conditional skip wrong");
	AST_ADDR_RANGE: assert property (cmd_go && !rd_ok && // RQ18
		code == CMD_RREG && rst_reg == R_IDLE |=>
		err_reg[EB_RANGE] && !rbus_req.valid)
		else $error("address above 31 not refused");
	AST_KEEP_DEST: assert property (rsp_take && // RQ23
		rbus_rsp.err != RE_OK && !wr_go |=> $stable(lreg[rdst_reg]))
		else $error("failed read changed destination");
	AST_TIMEOUT: assert property (err_set[EB_TOUT] |=> // RQ22
		err_reg[EB_TOUT] && rst_reg == R_IDLE)
		else $error("timeout flag not raised");
	AST_IN_BYTE: assert property (cmd_go && code == CMD_RDIN && // RQ12
		w_data[CF_ADR +: 5] == 5'h00 |=> res_reg[7:0] == $past(in_pins))
		else $error("input byte read wrong");
endmodule

//--- dv/ihb_exp_model.sv
// Behavioural expansion module answering remote reads
`timescale 1ns/1ps
module ihb_exp_model import ihb_pkg::*; (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Expansion bus from and to the block
	input wire ihb_rreq_t rbus_req,
	output ihb_rrsp_t rbus_rsp,
	// Behaviour chosen by the bench
	input wire logic [7:0] dly,
	input wire logic [1:0] err_code,
	input wire logic mute,
	output ihb_rreq_t last_req
);
	logic busy_reg; // A request is being served
	logic [7:0] cnt_reg; // Cycles left before the answer
	// Serve one request; idle data toggles so stale values never match
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_reg <= 1'b0;
			cnt_reg <= 8'h00;
			last_req <= '0;
			rbus_rsp <= '0;
		end else begin
			rbus_rsp.done <= 1'b0;
			rbus_rsp.data <= ~rbus_rsp.data;
			if (!busy_reg && rbus_req.valid && !rbus_rsp.done) begin
				busy_reg <= 1'b1;
				cnt_reg <= dly;
				last_req <= rbus_req;
			end else if (busy_reg && !rbus_req.valid) begin
				busy_reg <= 1'b0; // Abandoned by the block
			end else if (busy_reg && cnt_reg != 8'h00) begin
				cnt_reg <= cnt_reg - 8'h01;
			end else if (busy_reg && !mute) begin
				busy_reg <= 1'b0;
				rbus_rsp.done <= 1'b1;
				rbus_rsp.err <= err_code;
				rbus_rsp.data <= {11'h5a3, last_req.addr, 8'h81,
					last_req.item};
			end
		end
	end
endmodule

//--- dv/tb_top.sv
// Self-checking bench for halt, compare, input and remote reads
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top import ihb_pkg::*;;
	// Design inputs, all set at time zero
	logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, in_pins = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic nl = 1'b0, pl = 1'b0, hm = 1'b0, ai1 = 1'b0, ai2 = 1'b0;
	logic ofault = 1'b0, mute = 1'b0;
	logic [7:0] dly = 8'h02;
	logic [1:0] err_code = 2'h0;
	// Design outputs
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic halt_now, stop_req, home_req, hsse;
	logic [15:0] line_ptr;
	ihb_rreq_t rreq, last_req;
	ihb_rrsp_t rrsp;
	// Bench state
	int num_errors = 0, checked = 0;
	int n_halt = 0, n_stop = 0, n_home = 0, n_req = 0;
	logic req_d = 1'b0;
	logic [31:0] rdat;
	logic [1:0] rres, bres;
	ihb_core #(.TIMEOUT_CYC(16)) uut (.aclk(aclk), .aresetn(aresetn),
		.ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .in_pins(in_pins),
		.negative_limit_input(nl), .positive_limit_input(pl),
		.home_input(hm), .analogue_input_one(ai1),
		.analogue_input_two(ai2), .output_fault(ofault),
		.motor_halt_now(halt_now), .motor_stop_req(stop_req),
		.home_search_command(home_req), .high_speed_start_enable(hsse),
		.line_ptr(line_ptr), .rbus_req(rreq), .rbus_rsp(rrsp));
	ihb_exp_model partner (.aclk(aclk), .aresetn(aresetn),
		.rbus_req(rreq), .rbus_rsp(rrsp), .dly(dly),
		.err_code(err_code), .mute(mute), .last_req(last_req));
	// Free-running clock, 100 ns period
	initial begin
		forever #50 aclk = ~aclk;
	end
	// Count one-cycle pulses and new remote requests; counting on the
	// falling edge keeps the tallies settled before a task reads them
	always @(negedge aclk) begin
		n_halt += (halt_now === 1'b1);
		n_stop += (stop_req === 1'b1);
		n_home += (home_req === 1'b1);
		n_req += (rreq.valid === 1'b1 && !req_d);
		req_d <= (rreq.valid === 1'b1);
	end
	// Verdict and end of run
	task automatic finish_test;
		if (num_errors == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Write: address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic pa, pw, ha, hw;
		pa = 1'b1;
		pw = 1'b1;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (pa || pw) begin
			@(negedge aclk);
			ha = pa && (awready === 1'b1);
			hw = pw && (wready === 1'b1);
			@(posedge aclk);
			if (ha) begin
				pa = 1'b0;
				awvalid <= 1'b0;
			end
			if (hw) begin
				pw = 1'b0;
				wvalid <= 1'b0;
			end
		end
		do @(negedge aclk); while (bvalid !== 1'b1);
		bres = bresp;
		@(posedge aclk);
		bready <= 1'b0;
	endtask
	// Read one word into rdat and rres
	task automatic rd(input logic [7:0] a);
		logic h;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			h = (arready === 1'b1);
			@(posedge aclk);
		end while (!h);
		arvalid <= 1'b0;
		do @(negedge aclk); while (rvalid !== 1'b1);
		rdat = rdata;
		rres = rresp;
		@(posedge aclk);
		rready <= 1'b0;
	endtask
	// Poll status until no remote read is outstanding
	task automatic wait_idle;
		int k;
		k = 0;
		do begin
			rd(OFS_STAT);
			k++;
		end while (rdat[3] !== 1'b0 && k < 60);
		// A read that never finishes is a failure of its own
		if (rdat[3] !== 1'b0) num_errors++;
	endtask
	// Reset state, command readback and an unmapped place
	task automatic t_map;
		rd(OFS_STAT);
		`CHK(rdat, 32'h0)
		rd(8'h24);
		`CHK(rres, 2'h2)
		wr(8'h24, 32'h1);
		`CHK(bres, 2'h2)
		rd(OFS_CMD);
		`CHK(rdat, 32'h0)
	endtask
	// Halt from standby and from programming
	task automatic t_halt;
		wr(OFS_CTRL, 32'h1);
		`CHK(hsse, 1'b1)
		wr(OFS_CMD, CMD_HALT);
		`CHK(hsse, 1'b0)
		`CHK(n_halt, 1)
		rd(OFS_STAT);
		`CHK(rdat[2:0], 3'h0)
		wr(OFS_CMD, CMD_PROG);
		rd(OFS_STAT);
		`CHK(rdat[1:0], 2'h1)
		wr(OFS_CMD, CMD_HALT);
		rd(OFS_STAT);
		`CHK(rdat[1:0], 2'h0)
		`CHK(n_halt, 2)
	endtask
	// Motor stop while running, halt over a pending read, then rerun
	task automatic t_run;
		wr(OFS_CMD, CMD_EXEC);
		wr(OFS_CMD, CMD_MSTOP);
		`CHK(n_stop, 1)
		rd(OFS_STAT);
		`CHK(rdat[1:0], 2'h2)
		mute <= 1'b1;
		wr(OFS_CMD, {8'h01, 8'h02, 8'h01, 4'h0, CMD_RREG});
		`CHK(rreq.valid, 1'b1)
		wr(OFS_CMD, CMD_HALT);
		`CHK(rreq.valid, 1'b0)
		`CHK(n_halt, 3)
		rd(OFS_STAT);
		`CHK(rdat[1:0], 2'h0)
		mute <= 1'b0;
		wr(OFS_CMD, CMD_HOME);
		`CHK(n_home, 1)
		wr(OFS_CMD, CMD_EXEC);
		rd(OFS_STAT);
		`CHK(rdat[31:16], 16'h0)
		`CHK({rdat[2], rdat[1:0]}, 3'h2)
	endtask
	// One compare: operands, control, command, then result bit
	task automatic cmp(input logic [31:0] c, a, b, input logic e);
		logic [15:0] lp;
		wr(OFS_OPA, a);
		wr(OFS_OPB, b);
		wr(OFS_CMP, c);
		// Line pointer before the conditional, to see the skip
		lp = line_ptr;
		wr(OFS_CMD, CMD_IF);
		rd(OFS_STAT);
		`CHK(rdat[4], e)
		`CHK(rdat[31:16], lp + (e ? 16'h1 : 16'h2))
	endtask
	// Every operator, every operand source, masked pattern
	task automatic t_if;
		for (int i = 0; i < 4; i++) begin
			cmp(i, 32'hffff_ffff, 32'h1, i == 1 || i == 2);
			cmp(i, 32'h7, 32'h7, i == 3);
		end
		wr(OFS_LREG + 8'h08, 32'd100);
		cmp(32'h7, 32'h2, 32'd100, 1'b1);
		@(posedge aclk);
		in_pins <= 8'h80;
		pl <= 1'b1;
		ai2 <= 1'b1;
		cmp(32'hb, 32'd8, 32'h1, 1'b1);
		cmp(32'hb, 32'd10, 32'h1, 1'b1);
		cmp(32'hb, 32'd9, 32'h0, 1'b1);
		cmp(32'hb, 32'd13, 32'h1, 1'b1);
		in_pins <= 8'h1b;
		cmp(32'h1e0f, 32'h0, 32'h1a, 1'b1);
		in_pins <= 8'h13;
		cmp(32'h1e0f, 32'h0, 32'h1a, 1'b0);
		// Pointer has moved on; halt then execute must restart at zero
		wr(OFS_CMD, CMD_HALT);
		wr(OFS_CMD, CMD_EXEC);
		rd(OFS_STAT);
		`CHK(rdat[31:16], 16'h0)
	endtask
	// Input register and input read command
	task automatic t_inp;
		@(posedge aclk);
		in_pins <= 8'h96;
		{ofault, ai2, ai1, hm, pl, nl} <= 6'b110101;
		rd(OFS_INP);
		`CHK(rdat[15:0], 16'h5596)
		`CHK(rdat[7], 1'b1)
		// Input read results land in the result register
		wr(OFS_CMD, 32'h0000_0507);
		rd(OFS_RES);
		`CHK(rdat, 32'h96)
		wr(OFS_CMD, 32'h0008_0507);
		rd(OFS_RES);
		`CHK(rdat, 32'h1)
		wr(OFS_CMD, 32'h000c_0507);
		rd(OFS_RES);
		`CHK(rdat, 32'h0)
		wr(OFS_CMD, 32'h000f_0507);
		rd(OFS_RES);
		`CHK(rdat, 32'h1)
	endtask
	// Remote reads: good, slow, each fault, timeout, bad address
	task automatic t_remote;
		logic [4:0] eb[4] = '{5'h0, 5'h1, 5'h4, 5'h8};
		int n0;
		wr(OFS_CMD, {8'hff, 8'h1f, 8'h03, 4'h0, CMD_RREG});
		wait_idle();
		rd(OFS_LREG + 8'h0c);
		`CHK(rdat, {11'h5a3, 5'h1f, 8'h81, 8'hff})
		`CHK(last_req.addr, 5'h1f)
		`CHK(last_req.item, 8'hff)
		dly <= 8'h0c;
		wr(OFS_CMD, {8'h03, 8'h00, 8'h04, 4'h0, CMD_RFLAG});
		wait_idle();
		rd(OFS_LREG + 8'h10);
		`CHK(rdat, 32'h1)
		for (int e = 1; e < 5; e++) begin
			err_code <= e[1:0];
			mute <= (e == 4);
			wr(OFS_CMD, {8'h02, 8'h05, 8'h03, 4'h0, CMD_RREG});
			wait_idle();
			rd(OFS_ERR);
			`CHK(rdat[4:0], (e == 4) ? 5'h2 : eb[e])
			rd(OFS_LREG + 8'h0c);
			`CHK(rdat, {11'h5a3, 5'h1f, 8'h81, 8'hff})
			wr(OFS_ERR, 32'h1f);
		end
		mute <= 1'b0;
		n0 = n_req;
		wr(OFS_CMD, {8'h02, 8'h20, 8'h03, 4'h0, CMD_RREG});
		rd(OFS_ERR);
		`CHK(rdat[4], 1'b1)
		`CHK(n_req, n0)
	endtask
	// Main sequence
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_map();
		t_halt();
		t_run();
		t_if();
		t_inp();
		t_remote();
		finish_test();
	end
	// Watchdog against a hung handshake
	initial begin
		repeat (30000) @(posedge aclk);
		num_errors++;
		finish_test();
	end
endmodule
